// ===== dv/asm_link_model.sv
// far-end receiver: bit clock, frame sync, pin capture
`timescale 1ns/10ps
`default_nettype none
module asm_link_model (
	// link clock and sync
	output var logic  o_bclk,
	output var logic  o_fsync,
	// pins under test
	input  wire logic i_pri_dout,
	input  wire logic i_pri_oe,
	input  wire logic i_sec_dout,
	input  wire logic i_sec_oe
);
	// ==========
	// released pins are kept as z so idle never passes for data
	logic pri_got [256];
	logic sec_got [256];
	initial begin
		o_bclk = 1'b0;
		o_fsync = 1'b0;
	end
	function automatic logic fs(input logic [1:0] f, input int i);
		if (f == 2'h0) return i == 0;
		if (f == 2'h1) return !(i >= -1 && i < 127);
		return i >= 0 && i < 128;
	endfunction
	// clock stands low between frames; a lead-in rise shows the idle sync level
	task automatic run_frame(input logic [1:0] f);
		o_fsync = fs(f, -2);
		#1000;
		for (int i = -2; i <= 256; i++) begin
			o_bclk = 1'b1;
			if (i > 0) begin
				pri_got[i-1] = i_pri_oe ? i_pri_dout : 1'bz;
				sec_got[i-1] = i_sec_oe ? i_sec_dout : 1'bz;
			end
			#160 o_bclk = 1'b0;
			o_fsync = fs(f, i + 1);
			#160;
		end
	endtask
endmodule // asm_link_model
`default_nettype wire

// ===== dv/asm_slot_map_props.sv
// checker of the slot map ports
`timescale 1ns/10ps
`default_nettype none
module asm_slot_map_props (
	// clock, reset, registers
	input wire logic       I_CLK_SYS,
	input wire logic       I_RST_B,
	input wire logic       I_REG_WR,
	input wire logic       I_REG_RD,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [7:0] I_REG_WDATA,
	input wire logic [7:0] O_REG_RDATA,
	// serial side
	input wire logic       I_TX_FILL,
	input wire logic       I_BCLK,
	input wire logic       O_PRI_DOUT,
	input wire logic       O_PRI_OE,
	input wire logic       O_SEC_DOUT,
	input wire logic       O_SEC_OE
);
	// ==========
	// shadow maps
	logic [7:0] sh_q [3];
	logic [7:0] sh_d [3];
	logic [7:0] rd_exp;
	logic       hit;
	assign hit = I_REG_ADDR inside {[8'h0b:8'h0d]};
	assign rd_exp = sh_q[2'(I_REG_ADDR - 8'h0b)];
	always_comb begin
		sh_d = sh_q;
		if (I_REG_WR && hit) sh_d[2'(I_REG_ADDR - 8'h0b)] = I_REG_WDATA & 8'h7f;
	end
	always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
		if (!I_RST_B) sh_q <= '{8'h00, 8'h01, 8'h02};
		else sh_q <= sh_d;
	end
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_B);
	sequence s_rd_map;
		I_REG_RD && !I_REG_WR && hit;
	endsequence
	rd_top_bit_a:
		assert property (!O_REG_RDATA[7]) else $error("read bit 7 set");
	rd_unmapped_a:
		assert property (I_REG_RD && !I_REG_WR && !hit |=> O_REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	rd_mapped_a:
		assert property (s_rd_map |=> O_REG_RDATA == $past(rd_exp)) else $error("bad map read");
	pri_fill_hold_a:
		assert property (!I_TX_FILL && O_PRI_OE ##1 !I_TX_FILL |-> O_PRI_OE)
		else $error("primary released with zero fill");
	sec_fill_hold_a:
		assert property (!I_TX_FILL && O_SEC_OE ##1 !I_TX_FILL |-> O_SEC_OE)
		else $error("secondary released with zero fill");
	pri_on_fall_a:
		assert property ($changed(O_PRI_DOUT) |-> !$past(I_BCLK)) else $error("primary moved late");
	sec_on_fall_a:
		assert property ($changed(O_SEC_DOUT) |-> !$past(I_BCLK)) else $error("secondary moved late");
endmodule // asm_slot_map_props
bind asm_slot_map asm_slot_map_props u_props (
	.I_CLK_SYS   (I_CLK_SYS),
	.I_RST_B     (I_RST_B),
	.I_REG_WR    (I_REG_WR),
	.I_REG_RD    (I_REG_RD),
	.I_REG_ADDR  (I_REG_ADDR),
	.I_REG_WDATA (I_REG_WDATA),
	.O_REG_RDATA (O_REG_RDATA),
	.I_TX_FILL   (I_TX_FILL),
	.I_BCLK      (I_BCLK),
	.O_PRI_DOUT  (O_PRI_DOUT),
	.O_PRI_OE    (O_PRI_OE),
	.O_SEC_DOUT  (O_SEC_DOUT),
	.O_SEC_OE    (O_SEC_OE)
);
`default_nettype wire

// ===== dv/asm_slot_map_tb.sv
// self-checking bench of the channel slot map
`timescale 1ns/10ps
`default_nettype none
module asm_slot_map_tb;
	// ==========
	// 4-bit slots keep a 64-slot frame short
	localparam int SB = 4;
	logic          clk = 1'b0;
	logic          rst_b = 1'b0;
	logic          wr = 1'b0;
	logic          rd = 1'b0;
	logic          fill = 1'b0;
	logic [1:0]    fmt = 2'h0;
	logic [7:0]    addr = 8'h00;
	logic [7:0]    wdata = 8'h00;
	logic [7:0]    rdata;
	logic          pdo, poe, sdo, soe, bclk, fsync;
	logic [SB-1:0] w [3] = '{4'hb, 4'h3, 4'he};
	logic [7:0]    cfg [3] = '{8'h00, 8'h01, 8'h02};
	int            fail_count = 0;
	int            n_compared = 0;
	int            cyc = 0;
	always #20 clk = ~clk;
	asm_slot_map #(.SLOT_BITS(SB)) dut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_REG_WR(wr),
		.I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
		.I_FORMAT(fmt), .I_TX_FILL(fill), .I_BCLK(bclk), .I_FSYNC(fsync),
		.I_CH1_WORD(w[0]), .I_CH2_WORD(w[1]), .I_CH3_WORD(w[2]), .O_PRI_DOUT(pdo),
		.O_PRI_OE(poe), .O_SEC_DOUT(sdo), .O_SEC_OE(soe));
	asm_link_model link (.o_bclk(bclk), .o_fsync(fsync), .i_pri_dout(pdo),
		.i_pri_oe(poe), .i_sec_dout(sdo), .i_sec_oe(soe));
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic chk8(input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t reg got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic e, input logic g, input int p);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t bit %0d got %b exp %b", $time, p, g, e);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 wr = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1 wr = 1'b0;
		if (a inside {[8'h0b:8'h0d]}) cfg[2'(a - 8'h0b)] = d & 8'h7f;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		#1 rd = 1'b1;
		addr = a;
		@(posedge clk);
		#1 rd = 1'b0;
		@(posedge clk);
		#1 chk8(e, rdata);
	endtask
	// lowest channel wins a clash
	function automatic logic exp_bit(input logic pin, input int p);
		for (int c = 0; c < 3; c++)
			if (cfg[c][5:0] == 6'(p / SB) && cfg[c][6] == pin) return w[c][SB-1-p%SB];
		return fill ? 1'bz : 1'b0;
	endfunction
	task automatic t_frame(input logic [1:0] f, input logic l);
		@(posedge clk);
		#1 fmt = f;
		fill = l;
		link.run_frame(f);
		for (int p = 0; p < 256; p++) begin
			chk1(exp_bit(1'b0, p), link.pri_got[p], p);
			chk1(exp_bit(1'b1, p), link.sec_got[p], p);
		end
	endtask
	task automatic t_reset();
		rd_reg(8'h0b, 8'h00);
		rd_reg(8'h0c, 8'h01);
		rd_reg(8'h0d, 8'h02);
		rd_reg(8'h0a, 8'h00);
	endtask
	// edge slots 63 and 32 on the secondary pin, 31 on the primary
	task automatic t_regs();
		wr_reg(8'h0b, 8'hff);
		rd_reg(8'h0b, 8'h7f);
		wr_reg(8'h0e, 8'hff);
		rd_reg(8'h0e, 8'h00);
		wr_reg(8'h0c, 8'h9f);
		wr_reg(8'h0d, 8'he0);
		rd_reg(8'h0c, 8'h1f);
		rd_reg(8'h0d, 8'h60);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1 rst_b = 1'b1;
		t_reset();
		t_frame(2'h0, 1'b0);
		t_regs();
		for (int f = 0; f < 4; f++)
			for (int l = 0; l < 2; l++)
				t_frame(2'(f), 1'(l));
		end_sim();
	end
endmodule // asm_slot_map_tb
`default_nettype wire

// ===== logic/asm_cfg.svh
// register offsets, field positions and reset values of the channel slot map
`ifndef ASM_CFG_SVH
`define ASM_CFG_SVH

`define ASM_OFS_CHAN1_SLOT_MAP 8'h0b
`define ASM_OFS_CHAN2_SLOT_MAP 8'h0c
`define ASM_OFS_CHAN3_SLOT_MAP 8'h0d
`define ASM_RST_CHAN1_SLOT_MAP 8'h00
`define ASM_RST_CHAN2_SLOT_MAP 8'h01
`define ASM_RST_CHAN3_SLOT_MAP 8'h02
`define ASM_WR_MASK            8'h7f
`define ASM_PIN_SEL_BIT        6
`define ASM_SLOT_MSB           5
`define ASM_SLOT_HALF_BIT      5
`define ASM_SLOT_W             6
`define ASM_NUM_CHAN           3

`endif

// ===== logic/asm_map_if.sv
// carrier of the per-channel slot numbers and pin selects
`timescale 1ns/10ps
`default_nettype none
interface asm_map_if;
	asm_pkg::asm_slot_type slot_number [3];
	logic                  pin_select  [3];

	modport regs (output slot_number, output pin_select);
	modport core (input slot_number, input pin_select);
endinterface
`default_nettype wire

// ===== logic/asm_pkg.sv
// types shared by the channel slot map modules
package asm_pkg;
	typedef enum logic [1:0] {
		ASM_FMT_TDM,
		ASM_FMT_I2S,
		ASM_FMT_LJ
	} asm_format_type;

	typedef logic [5:0] asm_slot_type;
endpackage

// ===== logic/asm_regs.sv
// three slot map registers with a byte-wide write and read port
`timescale 1ns/10ps
`default_nettype none
`include "asm_cfg.svh"
module asm_regs (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	// register port
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_rdata,
	// decoded fields
	asm_map_if.regs         map
);
	// ==========================================================
	// storage
	logic [7:0] reg_q [3];
	logic [7:0] reg_d [3];
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	function automatic logic [1:0] decode(input logic [7:0] a, output logic hit);
		hit    = 1'b1;
		decode = 2'd0;
		unique case (a)
			`ASM_OFS_CHAN1_SLOT_MAP: decode = 2'd0;
			`ASM_OFS_CHAN2_SLOT_MAP: decode = 2'd1;
			`ASM_OFS_CHAN3_SLOT_MAP: decode = 2'd2;
			default:                 hit = 1'b0;
		endcase
	endfunction

	always_comb begin
		logic [1:0] idx;
		logic       hit;
		idx     = decode(i_addr, hit);
		reg_d   = reg_q;
		rdata_d = rdata_q;
		if (i_wr && hit) begin
			reg_d[idx] = i_wdata & `ASM_WR_MASK;
		end
		if (i_rd) begin
			// unmapped offsets read as zero
			rdata_d = hit ? reg_q[idx] : 8'h00;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			reg_q[0] <= `ASM_RST_CHAN1_SLOT_MAP;
			reg_q[1] <= `ASM_RST_CHAN2_SLOT_MAP;
			reg_q[2] <= `ASM_RST_CHAN3_SLOT_MAP;
			rdata_q  <= 8'h00;
		end else begin
			reg_q   <= reg_d;
			rdata_q <= rdata_d;
		end
	end

	always_comb begin
		for (int c = 0; c < `ASM_NUM_CHAN; c++) begin
			map.slot_number[c] = reg_q[c][`ASM_SLOT_MSB:0];
			map.pin_select[c]  = reg_q[c][`ASM_PIN_SEL_BIT];
		end
	end

	assign o_rdata = rdata_q;
endmodule // asm_regs
`default_nettype wire

// ===== logic/asm_slot_map.sv
// transmit slot and pin mapping of the audio serial port, channels 1 to 3
`timescale 1ns/10ps
`default_nettype none
`include "asm_cfg.svh"
module asm_slot_map #(
	parameter int SLOT_BITS = 32
) (
	// clock and reset
	input  wire logic                 I_CLK_SYS,
	input  wire logic                 I_RST_B,
	// register port
	input  wire logic                 I_REG_WR,
	input  wire logic                 I_REG_RD,
	input  wire logic [7:0]           I_REG_ADDR,
	input  wire logic [7:0]           I_REG_WDATA,
	output logic      [7:0]           O_REG_RDATA,
	// frame settings
	input  wire logic [1:0]           I_FORMAT,
	input  wire logic                 I_TX_FILL,
	// serial link inputs
	input  wire logic                 I_BCLK,
	input  wire logic                 I_FSYNC,
	// sample words from the converter datapath
	input  wire logic [SLOT_BITS-1:0] I_CH1_WORD,
	input  wire logic [SLOT_BITS-1:0] I_CH2_WORD,
	input  wire logic [SLOT_BITS-1:0] I_CH3_WORD,
	// serial outputs
	output logic                      O_PRI_DOUT,
	output logic                      O_PRI_OE,
	output logic                      O_SEC_DOUT,
	output logic                      O_SEC_OE
);
	localparam int BIT_W = $clog2(SLOT_BITS);
	localparam int CNT_W = `ASM_SLOT_W + BIT_W;

	// ==========================================================
	// register file
	asm_map_if map ();

	asm_regs u_regs (
		.i_clk   (I_CLK_SYS),
		.i_rst_b (I_RST_B),
		.i_wr    (I_REG_WR),
		.i_rd    (I_REG_RD),
		.i_addr  (I_REG_ADDR),
		.i_wdata (I_REG_WDATA),
		.o_rdata (O_REG_RDATA),
		.map     (map.regs)
	);

	// ==========================================================
	// link synchronisers
	// the bit clock is slow next to the system clock, so edges are found by sampling
	logic [2:0] bclk_q;
	logic [2:0] fsync_q;

	always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
		if (!I_RST_B) begin
			bclk_q  <= 3'h0;
			fsync_q <= 3'h0;
		end else begin
			bclk_q  <= {bclk_q[1:0], I_BCLK};
			fsync_q <= {fsync_q[1:0], I_FSYNC};
		end
	end

	logic bclk_rise;
	logic bclk_fall;
	logic fsync_s;
	assign bclk_rise = bclk_q[1] & ~bclk_q[2];
	assign bclk_fall = ~bclk_q[1] & bclk_q[2];
	assign fsync_s   = fsync_q[1];

	// ==========================================================
	// slot match
	function automatic logic chan_hit(
		input asm_pkg::asm_format_type fmt,
		input asm_pkg::asm_slot_type   slot,
		input logic [CNT_W-1:0]        cnt,
		input logic                    half
	);
		chan_hit = 1'b0;
		unique case (fmt)
			asm_pkg::ASM_FMT_TDM: begin
				chan_hit = (slot == cnt[CNT_W-1 -: `ASM_SLOT_W]);
			end
			default: begin
				// positions past slot 31 of a half carry no word
				chan_hit = !cnt[CNT_W-1]
					&& (slot[`ASM_SLOT_HALF_BIT] == half)
					&& (slot[4:0] == cnt[CNT_W-2 -: 5]);
			end
		endcase
	endfunction

	// ==========================================================
	// frame tracking and serial output
	asm_pkg::asm_format_type fmt;
	logic                    fs_prev_q;
	logic                    fs_prev_d;
	logic                    half_q;
	logic                    half_d;
	logic                    pend_q;
	logic                    pend_d;
	logic                    pend_half_q;
	logic                    pend_half_d;
	logic [CNT_W-1:0]        cnt_q;
	logic [CNT_W-1:0]        cnt_d;
	logic [SLOT_BITS-1:0]    word_q [3];
	logic [SLOT_BITS-1:0]    word_d [3];
	logic                    pri_dout_q;
	logic                    pri_dout_d;
	logic                    pri_oe_q;
	logic                    pri_oe_d;
	logic                    sec_dout_q;
	logic                    sec_dout_d;
	logic                    sec_oe_q;
	logic                    sec_oe_d;

	always_comb begin
		unique case (I_FORMAT)
			2'h0:    fmt = asm_pkg::ASM_FMT_TDM;
			2'h1:    fmt = asm_pkg::ASM_FMT_I2S;
			default: fmt = asm_pkg::ASM_FMT_LJ;
		endcase
	end

	always_comb begin
		logic             rise;
		logic             fall;
		logic             left_start;
		logic             right_start;
		logic             pri_hit;
		logic             sec_hit;
		logic [BIT_W-1:0] bit_idx;
		logic             capture;
		rise        = fsync_s & ~fs_prev_q;
		capture     = 1'b0;
		fall        = ~fsync_s & fs_prev_q;
		left_start  = 1'b0;
		right_start = 1'b0;
		pri_hit     = 1'b0;
		sec_hit     = 1'b0;
		bit_idx     = BIT_W'(SLOT_BITS - 1) - cnt_q[BIT_W-1:0];
		fs_prev_d   = fs_prev_q;
		half_d      = half_q;
		pend_d      = pend_q;
		pend_half_d = pend_half_q;
		cnt_d       = cnt_q;
		word_d      = word_q;
		pri_dout_d  = pri_dout_q;
		pri_oe_d    = pri_oe_q;
		sec_dout_d  = sec_dout_q;
		sec_oe_d    = sec_oe_q;
		unique case (fmt)
			asm_pkg::ASM_FMT_TDM: left_start = rise;
			asm_pkg::ASM_FMT_I2S: begin
				left_start  = fall;
				right_start = rise;
			end
			default: begin
				left_start  = rise;
				right_start = fall;
			end
		endcase
		// frame sync and data counters move on the sampling edge
		if (bclk_rise) begin
			fs_prev_d = fsync_s;
			cnt_d     = cnt_q + CNT_W'(1);
			pend_d    = 1'b0;
			// an I2S half starts one bit late: the bit under the sync edge still
			// belongs to the half before it, so the restart waits one edge
			if (pend_q) begin
				cnt_d   = '0;
				half_d  = pend_half_q;
				capture = ~pend_half_q;
			end
			if (left_start || right_start) begin
				if (fmt == asm_pkg::ASM_FMT_I2S) begin
					pend_d      = 1'b1;
					pend_half_d = right_start;
				end else begin
					cnt_d   = '0;
					half_d  = right_start;
					capture = left_start;
				end
			end
			if (capture) begin
				word_d[0] = I_CH1_WORD;
				word_d[1] = I_CH2_WORD;
				word_d[2] = I_CH3_WORD;
			end
		end
		// outputs change on the transmit edge; channel 1 wins a clash on one pin
		if (bclk_fall) begin
			pri_dout_d = 1'b0;
			sec_dout_d = 1'b0;
			for (int c = `ASM_NUM_CHAN - 1; c >= 0; c--) begin
				if (chan_hit(fmt, map.slot_number[c], cnt_q, half_q)) begin
					if (map.pin_select[c]) begin
						sec_hit    = 1'b1;
						sec_dout_d = word_q[c][bit_idx];
					end else begin
						pri_hit    = 1'b1;
						pri_dout_d = word_q[c][bit_idx];
					end
				end
			end
			// unused cycles: zero when fill is clear, released when set
			pri_oe_d = pri_hit | ~I_TX_FILL;
			sec_oe_d = sec_hit | ~I_TX_FILL;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
		if (!I_RST_B) begin
			fs_prev_q  <= 1'b0;
			half_q     <= 1'b0;
			pend_q     <= 1'b0;
			pend_half_q <= 1'b0;
			cnt_q      <= '0;
			word_q[0]  <= '0;
			word_q[1]  <= '0;
			word_q[2]  <= '0;
			pri_dout_q <= 1'b0;
			pri_oe_q   <= 1'b0;
			sec_dout_q <= 1'b0;
			sec_oe_q   <= 1'b0;
		end else begin
			fs_prev_q  <= fs_prev_d;
			half_q     <= half_d;
			pend_q     <= pend_d;
			pend_half_q <= pend_half_d;
			cnt_q      <= cnt_d;
			word_q     <= word_d;
			pri_dout_q <= pri_dout_d;
			pri_oe_q   <= pri_oe_d;
			sec_dout_q <= sec_dout_d;
			sec_oe_q   <= sec_oe_d;
		end
	end

	assign O_PRI_DOUT = pri_dout_q;
	assign O_PRI_OE   = pri_oe_q;
	assign O_SEC_DOUT = sec_dout_q;
	assign O_SEC_OE   = sec_oe_q;
endmodule // asm_slot_map
`default_nettype wire
